//--- verilog/mmc_mode_ctrl.sv
// mode-control registers of a serially programmed mux, with step-pin channel cycling
// assumes sclk, cs_n, sdi and the step pin come from outside the clock domain
// Operation
// - burst enable is bit 0 at 0x05
// - burst lets several frames share one select
// - frame clock count must be 16 without burst, a multiple of 16 with burst
// - cycle enable is bit 0 at 0x06
// - active step edge advances to next included channel
// - included channels visited in ascending order
// - mask at 0x07, one bit per channel
// - mask bit zero excludes, one includes
// - bit 0 at 0x09 picks rising edge
// - edge select acts only in cycle mode
// - writing 0xa3 then 0x05 restores defaults
// - reserved bits read as zero
`timescale 1ns/1ps
module mmc_mode_ctrl #(
  parameter int NUM_CH = 8
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  input  wire logic              step_trigger_pin,
  input  wire logic              count_check_en,
  output logic                   sdo,
  output logic                   sdo_oe,
  output logic                   frame_count_error,
  output logic      [NUM_CH-1:0] switch_select
);
  localparam int         IW       = $clog2(NUM_CH);
  localparam logic [7:0] MASK_RST = (NUM_CH == 8) ? mmc_pkg::MASK_RST8 : mmc_pkg::MASK_RST4;

  if (NUM_CH != 8 && NUM_CH != 4) begin : g_chk
    $error("NUM_CH must be 4 or 8");
  end

  logic [3:0] lv;
  logic [3:0] rs;
  logic [3:0] fl;

  mmc_sync #(.W(4), .RST_VAL(mmc_pkg::SY_RST)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({step_trigger_pin, sdi, cs_n, sclk}),
    .level (lv),
    .rise  (rs),
    .fall  (fl)
  );

  // serial frame state
  logic [14:0]         shift;
  logic [3:0]          cnt;
  logic                got;
  logic                extra;
  // one spare stage: the msb moves up on the first fall after the address, as mode 0 wants
  logic [8:0]          out;
  logic [14:0]         next_shift;
  logic [3:0]          next_cnt;
  logic                next_got;
  logic                next_extra;
  logic [8:0]          next_out;
  logic                next_err;
  logic                frame_done;
  logic                exec_wr;
  mmc_pkg::mmc_frame_t cmd;

  // register and channel state
  mmc_pkg::mmc_regs_t  r;
  mmc_pkg::mmc_regs_t  next_r;
  mmc_pkg::mmc_key_t   key;
  mmc_pkg::mmc_key_t   next_key;
  logic                soft_rst;
  logic                step_act;
  logic [IW-1:0]       idx;
  logic [IW-1:0]       next_idx;
  logic [NUM_CH-1:0]   next_sel;

  function automatic logic [7:0] rd_byte(input logic [6:0] a, input mmc_pkg::mmc_regs_t q);
    logic [7:0] v;
    v = mmc_pkg::RST_ZERO;
    case (a)
      mmc_pkg::ADDR_BURST: v[mmc_pkg::EN_BIT] = q.burst;
      mmc_pkg::ADDR_CYCLE: v[mmc_pkg::EN_BIT] = q.cycle;
      mmc_pkg::ADDR_MASK:  v = q.mask;
      mmc_pkg::ADDR_EDGE:  v[mmc_pkg::EN_BIT] = q.edge_rise;
      default:             v = mmc_pkg::RST_ZERO;
    endcase
    return v;
  endfunction

  // smallest included channel above the current one, else the lowest included
  function automatic logic [IW-1:0] nxt_ch(input logic [IW-1:0] cur, input logic [7:0] m);
    logic [IW-1:0] lo;
    logic [IW-1:0] up;
    logic          hit;
    lo  = cur;
    up  = cur;
    hit = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i]) begin
        lo = IW'(i);
        if (IW'(i) > cur) begin
          up  = IW'(i);
          hit = 1'b1;
        end
      end
    end
    return hit ? up : lo;
  endfunction

  assign cmd    = {shift, lv[mmc_pkg::SY_SDI]};
  assign sdo    = out[8];
  assign sdo_oe = ~lv[mmc_pkg::SY_CS];

  always_comb begin
    next_shift = shift;
    next_cnt   = cnt;
    next_got   = got;
    next_extra = extra;
    next_out   = out;
    next_err   = 1'b0;
    frame_done = 1'b0;
    if (fl[mmc_pkg::SY_CS]) begin
      next_cnt   = 4'h0;
      next_got   = 1'b0;
      next_extra = 1'b0;
      next_out   = '0;
    end else if (rs[mmc_pkg::SY_CS]) begin
      next_err = count_check_en & ((cnt != 4'h0) | extra);
    end else if (!lv[mmc_pkg::SY_CS] && rs[mmc_pkg::SY_SCLK]) begin
      next_shift = {shift[13:0], lv[mmc_pkg::SY_SDI]};
      next_cnt   = cnt + 4'h1; // wraps every 16 clocks, so a burst needs no reload
      if (cnt == mmc_pkg::CNT_ADDR_DONE && shift[6]) begin
        next_out = {1'b0, rd_byte({shift[5:0], lv[mmc_pkg::SY_SDI]}, r)};
      end
      if (cnt == mmc_pkg::CNT_FRAME_DONE) begin
        frame_done = 1'b1;
        next_got   = 1'b1;
        next_extra = extra | (got & ~r.burst);
      end
    end else if (!lv[mmc_pkg::SY_CS] && fl[mmc_pkg::SY_SCLK]) begin
      next_out = {out[7:0], 1'b0};
    end
  end

  // without burst only the first frame of a select is executed
  assign exec_wr = frame_done & ~cmd.rd & (~got | r.burst);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift             <= '0;
      cnt               <= 4'h0;
      got               <= 1'b0;
      extra             <= 1'b0;
      out               <= '0;
      frame_count_error <= 1'b0;
    end else begin
      shift             <= next_shift;
      cnt               <= next_cnt;
      got               <= next_got;
      extra             <= next_extra;
      out               <= next_out;
      frame_count_error <= next_err;
    end
  end

  // edge select is ignored outside cycle mode
  assign step_act = r.cycle & (r.edge_rise ? rs[mmc_pkg::SY_STEP]
                                           : fl[mmc_pkg::SY_STEP]);

  always_comb begin
    next_r   = r;
    next_key = key;
    soft_rst = 1'b0;
    next_idx = idx;
    if (exec_wr) begin
      case (cmd.addr)
        mmc_pkg::ADDR_BURST: next_r.burst     = cmd.data[mmc_pkg::EN_BIT];
        mmc_pkg::ADDR_CYCLE: next_r.cycle     = cmd.data[mmc_pkg::EN_BIT];
        mmc_pkg::ADDR_MASK:  next_r.mask      = cmd.data & MASK_RST;
        mmc_pkg::ADDR_EDGE:  next_r.edge_rise = cmd.data[mmc_pkg::EN_BIT];
        default:             next_r           = r;
      endcase
      // any other write between the two key bytes drops the sequence
      next_key = mmc_pkg::MMC_KEY_IDLE;
      if (cmd.addr == mmc_pkg::ADDR_KEY) begin
        case (key)
          mmc_pkg::MMC_KEY_ARMED: begin
            if (cmd.data == mmc_pkg::KEY_FIRE) begin
              soft_rst = 1'b1;
            end else if (cmd.data == mmc_pkg::KEY_ARM) begin
              next_key = mmc_pkg::MMC_KEY_ARMED;
            end
          end
          default: begin
            if (cmd.data == mmc_pkg::KEY_ARM) begin
              next_key = mmc_pkg::MMC_KEY_ARMED;
            end
          end
        endcase
      end
    end
    if (soft_rst) begin
      next_r   = '{burst: 1'b0, cycle: 1'b0, edge_rise: 1'b0, mask: MASK_RST};
      next_key = mmc_pkg::MMC_KEY_IDLE;
      next_idx = '0;
    end else if (step_act && (r.mask != 8'h00)) begin
      next_idx = nxt_ch(idx, r.mask);
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // in cycle mode, gating by the mask keeps an excluded channel off even before the first step
      next_sel[i] = (next_idx == IW'(i)) & (~next_r.cycle | next_r.mask[i]);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r             <= '{burst: 1'b0, cycle: 1'b0, edge_rise: 1'b0, mask: MASK_RST};
      key           <= mmc_pkg::MMC_KEY_IDLE;
      idx           <= '0;
      switch_select <= NUM_CH'(1);
    end else begin
      r             <= next_r;
      key           <= next_key;
      idx           <= next_idx;
      switch_select <= next_sel;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic has_up;
  assign has_up = ((r.mask[NUM_CH-1:0] >> idx) >> 1) != '0;

  soft_defaults_a: assert property (soft_rst |=> !r.burst && !r.cycle && !r.edge_rise
      && r.mask == MASK_RST && key == mmc_pkg::MMC_KEY_IDLE)
    else $error("soft reset left a register off its default");
  key_abandon_a: assert property (exec_wr && key == mmc_pkg::MMC_KEY_ARMED
      && cmd.data != mmc_pkg::KEY_FIRE && cmd.data != mmc_pkg::KEY_ARM
      |=> key == mmc_pkg::MMC_KEY_IDLE ##1 !soft_rst)
    else $error("broken key pair was not abandoned");
  step_up_a: assert property (step_act && has_up && !soft_rst |=> idx > $past(idx))
    else $error("step did not move to a higher channel");
  step_wrap_a: assert property (step_act && !has_up && r.mask != 8'h00 && !soft_rst
      |=> idx <= $past(idx))
    else $error("step past the top did not wrap");
  step_incl_a: assert property (step_act && r.mask != 8'h00 && !exec_wr |=> r.mask[idx])
    else $error("step landed on an excluded channel");
  no_cycle_a: assert property (!r.cycle && !soft_rst |=> $stable(idx))
    else $error("channel moved outside cycle mode");
  excl_off_a: assert property (r.cycle |-> (switch_select & ~r.mask[NUM_CH-1:0]) == '0)
    else $error("excluded channel switched on");
  count_err_a: assert property (rs[mmc_pkg::SY_CS] && count_check_en && cnt != 4'h0
      |=> frame_count_error ##1 !frame_count_error)
    else $error("partial frame not flagged");
  single_frame_a: assert property (frame_done && got && !r.burst |=> $stable(r) && $stable(key))
    else $error("second frame executed without burst");

  soft_seen_c:  cover property (soft_rst);
  wrap_seen_c:  cover property (step_act && !has_up && r.mask != 8'h00);
  burst_two_c:  cover property (exec_wr && got && r.burst);
  count_err_c:  cover property (frame_count_error);
endmodule

//--- inc/mmc_pkg.sv
// mode-control register group: offsets, reset values, frame layout, types
// assumes 16-bit serial frames: read flag, 7-bit address, 8-bit data
package mmc_pkg;
  localparam logic [6:0] ADDR_BURST = 7'h05;
  localparam logic [6:0] ADDR_CYCLE = 7'h06;
  localparam logic [6:0] ADDR_MASK  = 7'h07;
  localparam logic [6:0] ADDR_EDGE  = 7'h09;
  localparam logic [6:0] ADDR_KEY   = 7'h0b;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] MASK_RST8  = 8'hff;
  localparam logic [7:0] MASK_RST4  = 8'h0f;
  localparam logic [7:0] KEY_ARM    = 8'ha3;
  localparam logic [7:0] KEY_FIRE   = 8'h05;
  localparam int         EN_BIT     = 0;
  localparam int         FRAME_BITS = 16;
  localparam logic [3:0] CNT_ADDR_DONE  = 4'h7;
  localparam logic [3:0] CNT_FRAME_DONE = 4'hf;
  // sync bit positions
  localparam int         SY_SCLK = 0;
  localparam int         SY_CS   = 1;
  localparam int         SY_SDI  = 2;
  localparam int         SY_STEP = 3;
  localparam logic [3:0] SY_RST  = 4'h2;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } mmc_frame_t;

  typedef struct packed {
    logic       burst;
    logic       cycle;
    logic       edge_rise;
    logic [7:0] mask;
  } mmc_regs_t;

  typedef enum logic [1:0] {
    MMC_KEY_IDLE  = 2'b01,
    MMC_KEY_ARMED = 2'b10
  } mmc_key_t;
endpackage

//--- verilog/mmc_sync.sv
// three-stage synchroniser with filtered level and edge pulses
// assumes inputs asynchronous to clock; level moves once stages two and three agree
`timescale 1ns/1ps
module mmc_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
      rise[i]       = next_level[i] & ~level[i];
      fall[i]       = ~next_level[i] & level[i];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1    <= RST_VAL;
      s2    <= RST_VAL;
      s3    <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1    <= din;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule

//--- test/mmc_host_model.sv
// host model: serial frames (mode 0, msb first) and the step pin
// assumes the bench clock; every pin change lands on a falling clock edge
`timescale 1ns/1ps
module mmc_host_model (
  input  wire logic clock,
  input  wire logic sdo,
  output logic      sclk     = 1'b0,
  output logic      cs_n     = 1'b1,
  output logic      sdi      = 1'b0,
  output logic      step_pin = 1'b0
);
  // 6 clocks low, 7 high: 65 ns, the nearest whole-clock period to 64 ns
  task automatic half();
    repeat (6) @(negedge clock);
  endtask
  task automatic sel(input logic on);
    half();
    cs_n = ~on;
    // released line must not keep showing the last bit
    if (!on) sdi = ~sdi;
    half();
  endtask
  // n bits from tx[15] down; burst frames share one select
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - n; i--) begin
      sdi = tx[i];
      half();
      sclk  = 1'b1;
      rx[i] = sdo;
      half();
      @(negedge clock);
      sclk = 1'b0;
    end
  endtask
  // one edge; spacing far above the 2-clock minimum
  task automatic step();
    @(negedge clock);
    step_pin = ~step_pin;
    repeat (10) @(negedge clock);
  endtask
endmodule

//--- test/testbench.sv
// self-checking bench for mmc_mode_ctrl through its serial register port
// assumes mmc_host_model drives the pins; sclk low for 6 clocks, high for 7
`timescale 1ns/1ps
module testbench;
  logic        clock, rstn, chk_en, sclk, cs_n, sdi, step_pin, sdo, sdo_oe, fce;
  logic [7:0]  sw;
  logic [15:0] rx;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n_fce = 0;
  logic [7:0]  e [8] = '{8'h01, 8'h04, 8'h04, 8'h20, 8'h20, 8'h01, 8'h04, 8'h04};
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  mmc_mode_ctrl #(.NUM_CH(8)) i_dut (
    .clock             (clock),
    .rstn              (rstn),
    .sclk              (sclk),
    .cs_n              (cs_n),
    .sdi               (sdi),
    .step_trigger_pin  (step_pin),
    .count_check_en    (chk_en),
    .sdo               (sdo),
    .sdo_oe            (sdo_oe),
    .frame_count_error (fce),
    .switch_select     (sw)
  );
  mmc_host_model i_host (
    .clock    (clock),
    .sdo      (sdo),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .step_pin (step_pin)
  );
  // error is a one-cycle pulse; the falling edge sees it settled
  always @(negedge clock) if (fce === 1'b1) n_fce++;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.sel(1'b1);
    i_host.xfer({1'b0, a, d}, 16, rx);
    i_host.sel(1'b0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    i_host.sel(1'b1);
    i_host.xfer({1'b1, a, 8'h00}, 16, rx);
    i_host.sel(1'b0);
    chk(rx[7:0], exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end
  initial begin
    rstn   = 1'b0;
    chk_en = 1'b1;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    chk(sw, 8'h01);
    chk({7'h00, sdo_oe}, 8'h00);
    rd(7'h05, 8'h00);
    rd(7'h06, 8'h00);
    rd(7'h07, 8'hff);
    rd(7'h09, 8'h00);
    rd(7'h0b, 8'h00);
    rd(7'h7f, 8'h00);
    $display("test reset done");
    // reserved bits written on purpose to see them read back as zero
    wr(7'h05, 8'hff);
    rd(7'h05, 8'h01);
    wr(7'h09, 8'hfe);
    rd(7'h09, 8'h00);
    wr(7'h06, 8'hfe);
    rd(7'h06, 8'h00);
    wr(7'h05, 8'h00);
    $display("test regs done");
    wr(7'h07, 8'h25);
    wr(7'h06, 8'h01);
    chk(sw, 8'h01);
    for (int k = 0; k < 8; k++) begin
      if (k == 6) wr(7'h09, 8'h01);
      i_host.step();
      chk(sw, e[k]);
    end
    wr(7'h06, 8'h00);
    i_host.step();
    i_host.step();
    chk(sw, 8'h04);
    $display("test cycle done");
    wr(7'h05, 8'h01);
    wr(7'h0b, 8'ha3);
    wr(7'h05, 8'h01);
    wr(7'h0b, 8'h05);
    rd(7'h05, 8'h01);
    wr(7'h0b, 8'ha3);
    wr(7'h0b, 8'h00);
    wr(7'h0b, 8'h05);
    rd(7'h05, 8'h01);
    wr(7'h0b, 8'ha3);
    wr(7'h0b, 8'h05);
    chk(sw, 8'h01);
    rd(7'h05, 8'h00);
    rd(7'h07, 8'hff);
    rd(7'h09, 8'h00);
    $display("test soft reset done");
    i_host.sel(1'b1);
    chk({7'h00, sdo_oe}, 8'h01);
    i_host.xfer(16'h0601, 16, rx);
    i_host.xfer(16'h0901, 16, rx);
    i_host.sel(1'b0);
    rd(7'h09, 8'h00);
    chk(n_fce[7:0], 8'h01);
    wr(7'h05, 8'h01);
    i_host.sel(1'b1);
    i_host.xfer(16'h0901, 16, rx);
    i_host.xfer(16'h07f0, 16, rx);
    i_host.sel(1'b0);
    rd(7'h09, 8'h01);
    rd(7'h07, 8'hf0);
    chk(n_fce[7:0], 8'h01);
    i_host.sel(1'b1);
    i_host.xfer(16'h0500, 16, rx);
    i_host.xfer(16'h0000, 3, rx);
    i_host.sel(1'b0);
    chk(n_fce[7:0], 8'h02);
    rd(7'h05, 8'h00);
    chk_en = 1'b0;
    i_host.sel(1'b1);
    i_host.xfer(16'h0000, 5, rx);
    i_host.sel(1'b0);
    chk(n_fce[7:0], 8'h02);
    $display("test burst done");
    test_done();
  end
endmodule
